// *** design/load_store_unit.sv ***
`timescale 1ns/10ps
`include "lsu_consts.svh"

// What this block does
// - signed loads sign-extend; unsigned loads zero-fill upper bits
// - aligned form: dword needs multiple of 8, word 4, half 2; else address error
// - first isa level no stall; later levels stall dependent op until data
// - only address mode is base register plus offset in -32768..32767
// - 16-bit offset is sign-extended before adding to the base
// - doubleword forms are accepted only at the third isa level or later
// - sync completes all earlier loads and stores before later accesses
module load_store_unit
    import lsu_pkg::*;
#(
    parameter int XLEN = 64
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [1:0]        isaLevel,
    input  wire logic              reqValid,
    input  wire access_op_e        reqOp,
    input  wire access_size_e      reqSize,
    input  wire access_form_e      reqForm,
    input  wire logic              reqUnsigned,
    input  wire logic [XLEN-1:0]   reqBase,
    input  wire logic [15:0]       reqOffset,
    input  wire logic [4:0]        reqDest,
    input  wire logic [XLEN-1:0]   reqStoreData,
    input  wire logic              useValid,
    input  wire logic [4:0]        useSrcA,
    input  wire logic [4:0]        useSrcB,
    output logic                   reqReady,
    output logic                   useStall,
    output logic                   addrError,
    output logic                   memReq,
    output logic                   memWrite,
    output logic [XLEN-1:0]        memAddr,
    output logic [7:0]             memByteEn,
    output logic [63:0]            memWriteData,
    input  wire logic              memAck,
    input  wire logic [63:0]       memReadData,
    output logic                   wbValid,
    output logic [4:0]             wbDest,
    output logic [XLEN-1:0]        wbData
);

    // ------------------------------------------------------------
    // address and checks
    // ------------------------------------------------------------
    wire logic [XLEN-1:0] offsetExt;
    wire logic [XLEN-1:0] effAddr;
    wire logic [2:0]      lowAddr;
    wire logic [2:0]      alignMask;
    wire logic            misaligned;
    wire logic            isDword;
    wire logic            dwordIllegal;
    wire logic            badAccess;
    wire logic            isMemOp;
    wire logic [7:0]      laneMask;
    wire logic            interlockOn;
    wire logic            depHit;

    assign offsetExt = {{(XLEN-`OFFSET_WIDTH){reqOffset[`OFFSET_SIGN_BIT]}},
                        reqOffset};
    assign effAddr = reqBase + offsetExt;
    assign lowAddr = effAddr[2:0];
    assign alignMask = (reqSize == SIZE_DWORD) ? `ALIGN_MASK_DWORD :
                       (reqSize == SIZE_WORD)  ? `ALIGN_MASK_WORD  :
                       (reqSize == SIZE_HALF)  ? `ALIGN_MASK_HALF  : 3'h0;
    assign misaligned = (reqForm == FORM_ALIGNED) &&
                        ((lowAddr & alignMask) != 3'h0);
    assign isDword = (reqSize == SIZE_DWORD);
    assign dwordIllegal = isDword && (isaLevel < `ISA_LEVEL_THIRD);
    assign isMemOp = (reqOp != OP_SYNC);
    assign badAccess = isMemOp && (misaligned || dwordIllegal);
    assign laneMask = laneSel(reqSize, reqForm, lowAddr);
    assign interlockOn = (isaLevel != `ISA_LEVEL_FIRST);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] laneSel(access_size_e sz,
                                           access_form_e fm,
                                           logic [2:0] a);
        logic [7:0] base;
        base = (sz == SIZE_DWORD) ? 8'hff :
               (sz == SIZE_WORD)  ? 8'h0f :
               (sz == SIZE_HALF)  ? 8'h03 : 8'h01;
        if (fm == FORM_LEFT) begin
            laneSel = base & (8'hff >> (3'h7 - a));
        end else if (fm == FORM_RIGHT) begin
            laneSel = base << a;
        end else begin
            laneSel = base << a;
        end
    endfunction

    function automatic logic [XLEN-1:0] extendData(logic [63:0] raw,
                                                   access_size_e sz,
                                                   logic uns);
        logic sgn;
        sgn = 1'b0;
        unique case (sz)
            SIZE_BYTE: begin
                sgn = raw[7] & ~uns;
                extendData = {{(XLEN-8){sgn}}, raw[7:0]};
            end
            SIZE_HALF: begin
                sgn = raw[15] & ~uns;
                extendData = {{(XLEN-16){sgn}}, raw[15:0]};
            end
            SIZE_WORD: begin
                sgn = raw[31] & ~uns;
                extendData = {{(XLEN-32){sgn}}, raw[31:0]};
            end
            SIZE_DWORD: begin
                extendData = raw[XLEN-1:0];
            end
        endcase
    endfunction

    // ------------------------------------------------------------
    // control state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUSY,
        ST_SYNC
    } lsu_state_e;

    lsu_state_e   state;
    logic         pendLoad;
    logic [4:0]   pendDest;
    access_size_e pendSize;
    logic         pendUnsigned;
    logic [2:0]   pendShift;

    wire logic accept;
    wire logic launch;
    assign accept = reqValid && reqReady;
    assign launch = accept && isMemOp && !badAccess;

    assign depHit = pendLoad && interlockOn && useValid && (pendDest != 5'h0)
                    && ((useSrcA == pendDest) ||
                        (useSrcB == pendDest));

    wire logic [63:0] shiftedRead;
    assign shiftedRead = memReadData >> {pendShift, 3'h0};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            pendLoad <= 1'b0;
            pendDest <= 5'h0;
            pendSize <= SIZE_BYTE;
            pendUnsigned <= 1'b0;
            pendShift <= 3'h0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (launch) begin
                        state <= ST_BUSY;
                        pendLoad <= (reqOp == OP_LOAD);
                        pendDest <= reqDest;
                        pendSize <= reqSize;
                        pendUnsigned <= reqUnsigned;
                        pendShift <= (reqForm == FORM_ALIGNED ||
                                      reqForm == FORM_UNALIGNED) ?
                                     lowAddr : 3'h0;
                    end else if (accept && reqOp == OP_SYNC) begin
                        state <= ST_SYNC;
                    end
                end
                ST_BUSY: begin
                    if (memAck) begin
                        state <= ST_IDLE;
                        pendLoad <= 1'b0;
                    end
                end
                ST_SYNC: begin
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reqReady <= 1'b0;
            useStall <= 1'b0;
            addrError <= 1'b0;
            memReq <= 1'b0;
            memWrite <= 1'b0;
            memAddr <= '0;
            memByteEn <= 8'h00;
            memWriteData <= 64'h0;
            wbValid <= 1'b0;
            wbDest <= 5'h0;
            wbData <= '0;
        end else begin
            // one request at a time; sync holds off later access
            reqReady <= (state == ST_IDLE) && !accept;
            useStall <= depHit && !memAck;
            addrError <= accept && badAccess;
            wbValid <= 1'b0;
            if (launch) begin
                memReq <= 1'b1;
                memWrite <= (reqOp == OP_STORE);
                memAddr <= effAddr;
                memByteEn <= laneMask;
                memWriteData <= 64'(reqStoreData) << {lowAddr, 3'h0};
            end else if (memAck) begin
                memReq <= 1'b0;
                memWrite <= 1'b0;
                memByteEn <= 8'h00;
            end
            if (state == ST_BUSY && memAck && pendLoad) begin
                wbValid <= 1'b1;
                wbDest <= pendDest;
                wbData <= extendData(shiftedRead, pendSize,
                                     pendUnsigned);
            end
        end
    end

endmodule // load_store_unit

// *** common/lsu_consts.svh ***
`ifndef LSU_CONSTS_SVH
`define LSU_CONSTS_SVH
// isa levels
`define ISA_LEVEL_FIRST  2'd0
`define ISA_LEVEL_SECOND 2'd1
`define ISA_LEVEL_THIRD  2'd2
`define ISA_LEVEL_FOURTH 2'd3
// alignment masks on low address bits
`define ALIGN_MASK_HALF  3'h1
`define ALIGN_MASK_WORD  3'h3
`define ALIGN_MASK_DWORD 3'h7
// offset field
`define OFFSET_WIDTH     16
`define OFFSET_SIGN_BIT  15
`endif

// *** common/lsu_pkg.sv ***
package lsu_pkg;
    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_HALF,
        SIZE_WORD,
        SIZE_DWORD
    } access_size_e;
    typedef enum logic [1:0] {
        FORM_ALIGNED,
        FORM_LEFT,
        FORM_RIGHT,
        FORM_UNALIGNED
    } access_form_e;
    typedef enum logic [1:0] {
        OP_LOAD,
        OP_STORE,
        OP_SYNC
    } access_op_e;
endpackage

// *** dv/mem_model.sv ***
`timescale 1ns/10ps
// --------
// memory side: acks each request after lat idle cycles
// --------
module mem_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        memReq,
    input  wire logic [3:0]  lat,
    input  wire logic [63:0] fill,
    output logic             memAck,
    output logic [63:0]      memReadData
);
    logic [3:0] cnt;
    wire        wait_ = memReq && !memAck;
    // released bus shows the inverse of the last data
    assign memReadData = memAck ? fill : ~fill;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 4'h0;
            memAck <= 1'b0;
        end else begin
            cnt <= (wait_ && cnt < lat) ? cnt + 4'h1 : 4'h0;
            memAck <= wait_ && cnt >= lat;
        end
    end
endmodule // mem_model

// *** dv/load_store_unit_checker.sv ***
`timescale 1ns/10ps
module load_store_unit_checker
    import lsu_pkg::*;
#(
    parameter int XLEN = 64
) (
    input wire logic            clk,
    input wire logic            rst_b,
    input wire logic [1:0]      isaLevel,
    input wire logic            reqValid,
    input wire access_op_e      reqOp,
    input wire access_size_e    reqSize,
    input wire access_form_e    reqForm,
    input wire logic [XLEN-1:0] reqBase,
    input wire logic [15:0]     reqOffset,
    input wire logic            reqReady,
    input wire logic            useStall,
    input wire logic            addrError,
    input wire logic            memReq,
    input wire logic            memWrite,
    input wire logic [XLEN-1:0] memAddr,
    input wire logic            memAck,
    input wire logic            wbValid
);
    wire t = reqValid && reqReady;
    wire take = t && reqOp != OP_SYNC;
    wire [XLEN-1:0] ea = reqBase + XLEN'($signed(reqOffset));
    wire mis = reqForm == FORM_ALIGNED && (reqSize == SIZE_HALF && ea[0]
        || reqSize == SIZE_WORD && ea[1:0] != 2'h0
        || reqSize == SIZE_DWORD && ea[2:0] != 3'h0);
    wire lowDw = reqSize == SIZE_DWORD && isaLevel < 2'h2;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_EA: assert property (
        take && !mis && !lowDw |=> memReq && memAddr == $past(ea))
        else $error("wrong address");
    AST_ALIGN: assert property (
        take && mis |=> addrError && !memReq) else $error("no align error");
    AST_DWORD: assert property (
        take && lowDw |=> addrError) else $error("dword accepted");
    AST_SYNC: assert property (
        t && reqOp == OP_SYNC |=> !memReq [*2]) else $error("sync access");
    AST_ONE: assert property (
        memReq |-> !reqReady) else $error("ready while busy");
    AST_NOSTALL: assert property (
        isaLevel == 2'h0 && $past(isaLevel) == 2'h0 |-> !useStall)
        else $error("stall at first level");
    AST_WB: assert property (
        memReq && memAck && !memWrite |=> wbValid) else $error("no wb");
    AST_HOLD: assert property (
        memReq && !memAck |=> memReq && $stable(memAddr))
        else $error("request dropped");
    AST_PULSE: assert property (
        addrError |=> !addrError) else $error("error not a pulse");
    COV_LOAD: cover property (memReq && memAck && !memWrite);
    COV_ERR: cover property (addrError);
    COV_STALL: cover property (useStall);
endmodule // load_store_unit_checker

bind load_store_unit load_store_unit_checker #(.XLEN(XLEN)) chk_i (
    .clk(clk), .rst_b(rst_b), .isaLevel(isaLevel), .reqValid(reqValid),
    .reqOp(reqOp), .reqSize(reqSize), .reqForm(reqForm),
    .reqBase(reqBase), .reqOffset(reqOffset), .reqReady(reqReady),
    .useStall(useStall), .addrError(addrError), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .memAck(memAck),
    .wbValid(wbValid));

// *** dv/load_store_unit_test.sv ***
`timescale 1ns/10ps
module load_store_unit_test
    import lsu_pkg::*;
;
    logic clk, rst_b, reqValid, reqUnsigned, useValid, memAck, stallSeen;
    logic reqReady, useStall, addrError, memReq, memWrite, wbValid;
    logic [63:0] reqBase, reqStoreData, memReadData, fill, memAddr;
    logic [63:0] memWriteData, wbData;
    logic [15:0] reqOffset;
    logic [4:0]  reqDest, useSrcA, useSrcB, wbDest;
    logic [3:0]  lat;
    logic [7:0]  memByteEn;
    logic [1:0]  isaLevel;
    access_op_e   reqOp;
    access_size_e reqSize;
    access_form_e reqForm;
    int err_count, tests_run;
    load_store_unit #(.XLEN(64)) dut (
        .clk(clk), .rst_b(rst_b), .isaLevel(isaLevel), .reqValid(reqValid),
        .reqOp(reqOp), .reqSize(reqSize), .reqForm(reqForm),
        .reqUnsigned(reqUnsigned), .reqBase(reqBase), .reqOffset(reqOffset),
        .reqDest(reqDest), .reqStoreData(reqStoreData), .useValid(useValid),
        .useSrcA(useSrcA), .useSrcB(useSrcB), .reqReady(reqReady),
        .useStall(useStall), .addrError(addrError), .memReq(memReq),
        .memWrite(memWrite), .memAddr(memAddr), .memByteEn(memByteEn),
        .memWriteData(memWriteData), .memAck(memAck),
        .memReadData(memReadData), .wbValid(wbValid), .wbDest(wbDest),
        .wbData(wbData));
    mem_model mem (.clk(clk), .rst_b(rst_b), .memReq(memReq), .lat(lat),
        .fill(fill), .memAck(memAck), .memReadData(memReadData));
    // --------
    // tasks
    // --------
    task chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task req(input access_op_e op, input access_size_e sz,
             input access_form_e fm, input logic un, input logic [15:0] o);
        int n;
        reqOp <= op;
        reqSize <= sz;
        reqForm <= fm;
        reqUnsigned <= un;
        reqOffset <= o;
        reqValid <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!reqReady && n < 40);
        chk(reqReady, 1'b1);
        reqValid <= 1'b0;
    endtask
    task wait_ev;
        int n;
        n = 0;
        stallSeen = 1'b0;
        do begin
            @(posedge clk);
            stallSeen |= useStall;
            n++;
        end while (!(wbValid || addrError || memWrite && memAck) && n < 40);
        chk(n < 40, 1'b1);
    endtask
    function logic [63:0] ext(input logic [63:0] d, input int s, input bit u);
        logic [63:0] m;
        m = (s == 3) ? '1 : (64'h1 << (8 << s)) - 64'h1;
        d = d & m;
        if (!u && d[(8 << s) - 1])
            d = d | ~m;
        return d;
    endfunction
    task t_ext;
        for (int s = 0; s < 4; s++) begin
            for (int u = 0; u < 2; u++) begin
                req(OP_LOAD, access_size_e'(s), FORM_ALIGNED, u[0], 16'hfff8);
                wait_ev();
                chk(wbData, ext(fill, s, u[0]));
                chk(wbDest, 5'h5);
            end
        end
    endtask
    task t_store;
        req(OP_STORE, SIZE_BYTE, FORM_ALIGNED, 1'b0, 16'hfffb);
        wait_ev();
        chk(memWrite, 1'b1);
        chk(memByteEn, 8'h08);
        chk(memWriteData[31:24], 8'h55);
        chk(memAddr, 64'h1003);
    endtask
    task t_align;
        for (int s = 1; s < 4; s++) begin
            for (int f = 0; f < 4; f++) begin
                req(OP_LOAD, access_size_e'(s), access_form_e'(f), 1'b0,
                    16'hfff9);
                wait_ev();
                chk(addrError, f == 0);
                if (f != 0)
                    chk(wbData, ext(f == 3 ? fill >> 8 : fill, s,
                                    1'b0));
            end
        end
        isaLevel <= 2'h1;
        req(OP_LOAD, SIZE_DWORD, FORM_ALIGNED, 1'b0, 16'hfff8);
        wait_ev();
        chk(addrError, 1'b1);
    endtask
    task t_stall;
        lat <= 4'h6;
        useValid <= 1'b1;
        for (int l = 1; l >= 0; l--) begin
            isaLevel <= 2'(l);
            req(OP_LOAD, SIZE_WORD, FORM_ALIGNED, 1'b0, 16'hfff8);
            wait_ev();
            chk(stallSeen, l[0]);
        end
        req(OP_SYNC, SIZE_WORD, FORM_ALIGNED, 1'b0, 16'h0000);
        repeat (3) @(posedge clk);
        chk(memReq, 1'b0);
        chk(reqReady, 1'b1);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #50000;
        err_count++;
        close_out();
    end
    initial begin
        {rst_b, reqValid, reqUnsigned, useValid} <= 4'h0;
        reqOp <= OP_LOAD;
        reqSize <= SIZE_BYTE;
        reqForm <= FORM_ALIGNED;
        {reqOffset, reqDest, useSrcA, useSrcB} <= {16'h0, 5'h5, 5'h5, 5'h0};
        {reqBase, reqStoreData} <= {64'h1008, 64'h55};
        {isaLevel, lat, fill} <= {2'h2, 4'h1, 64'h8899aabbccddeef0};
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_ext();
        t_store();
        t_align();
        t_stall();
        close_out();
    end
endmodule // load_store_unit_test
